// >>> logic/debounce_if.sv
`timescale 1ns/100ps
`default_nettype none

interface debounce_if;
  logic raw_n;
  logic clean_n;
  logic press;

  modport filt (
    input raw_n,
    output clean_n,
    output press
  );

  modport user (
    output raw_n,
    input clean_n,
    input press
  );
endinterface : debounce_if

`default_nettype wire

// >>> logic/mr_debounce.sv
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_defs.svh"

module mr_debounce #(
  parameter int DEBOUNCE_CYCLES = `SUP_DEBOUNCE_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  debounce_if.filt port
);

  localparam int DW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam logic [DW-1:0] DEB_LAST = DW'(DEBOUNCE_CYCLES - 1);

  generate
    if (DEBOUNCE_CYCLES < 1) begin : g_bad_deb
      $error("debounce count must be at least one");
    end
  endgenerate

  logic clean_n_reg;
  logic clean_n_next;
  logic [DW-1:0] stable_cnt_reg;
  logic [DW-1:0] stable_cnt_next;
  logic press_reg;

  wire differs = port.raw_n ^ clean_n_reg;
  wire settled = differs & (stable_cnt_reg == DEB_LAST);

  // bounce restarts the wait, so a chattering contact gives one change
  assign stable_cnt_next = (differs & ~settled) ?
                           stable_cnt_reg + DW'(1) : '0;
  assign clean_n_next = settled ? port.raw_n : clean_n_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      // released level, as an open pin pulled up reads
      clean_n_reg <= 1'b1;
      stable_cnt_reg <= '0;
      press_reg <= 1'b0;
    end else begin
      clean_n_reg <= clean_n_next;
      stable_cnt_reg <= stable_cnt_next;
      press_reg <= settled & ~port.raw_n;
    end
  end

  assign port.clean_n = clean_n_reg;
  assign port.press = press_reg;

endmodule : mr_debounce

`default_nettype wire

// >>> logic/supervisor_defs.svh
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH

// internal clock rate
`define SUP_CLK_MHZ 250

// reset hold after every source clears, least time
`define SUP_HOLD_MS 140
`define SUP_HOLD_CYCLES (`SUP_HOLD_MS * 1000 * `SUP_CLK_MHZ)

// kick window, 1.6 s nominal, written in ms
`define SUP_KICK_WINDOW_MS 1600
`define SUP_KICK_CYCLES (`SUP_KICK_WINDOW_MS * 1000 * `SUP_CLK_MHZ)

// floating-pin driver goes high for the last 1/8 of the window
`define SUP_KICK_HIGH_DIV 8

// shortest kick pulse that must be seen, least time rounds up
`define SUP_KICK_PULSE_NS 50
`define SUP_KICK_PULSE_CYCLES \
  ((`SUP_KICK_PULSE_NS * `SUP_CLK_MHZ + 999) / 1000)

// manual reset must be stable this long before it is believed
`define SUP_DEBOUNCE_NS 200
`define SUP_DEBOUNCE_CYCLES \
  ((`SUP_DEBOUNCE_NS * `SUP_CLK_MHZ + 999) / 1000)

// reset cause bit positions
`define SUP_CAUSE_UNDERVOLT 0
`define SUP_CAUSE_MANUAL 1
`define SUP_CAUSE_KICK 2
`define SUP_CAUSE_W 3

`endif

// >>> logic/supervisor_pkg.sv
`default_nettype none

package supervisor_pkg;

  typedef enum logic [2:0] {
    ST_ASSERT = 3'h1,
    ST_HOLD = 3'h2,
    ST_RUN = 3'h4
  } sup_state_t;

endpackage : supervisor_pkg

`default_nettype wire

// >>> logic/supervisor_reset_watchdog.sv
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_defs.svh"

// Operation
// - active-low reset falls on undervoltage, manual reset low, or kick timeout.
// - active-high reset output is always the complement of the low one.
// - after undervoltage clears, reset holds for the hold period, then releases.
// - reset holds while manual reset is low, then the hold period after.
// - an open manual reset input reads as released, requesting nothing.
// - manual reset is debounced inside so a bouncing switch gives one reset.
// - processor toggles kick input within the window, else reset is held.
// - kick counter clears in reset, on manual reset, and on every kick edge.
// - kick pulses as short as 50 ns clear the counter.
// - kick counter sits at zero and does not count while reset is held.
// - kick counter starts counting at once when reset releases.
// - open or three-stated kick input acts as a disabled watchdog.
// - kick node driven low for 7/8 of the window, high last 1/8.
module supervisor_reset_watchdog #(
  parameter int HOLD_CYCLES = `SUP_HOLD_CYCLES,
  parameter int KICK_CYCLES = `SUP_KICK_CYCLES,
  parameter int DEBOUNCE_CYCLES = `SUP_DEBOUNCE_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic undervolt_in,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  output logic kick_drive_out,
  output logic kick_drive_oe,
  output logic sys_rst_n_out,
  output logic sys_rst_out,
  output logic [`SUP_CAUSE_W-1:0] reset_cause_out
);

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int KW = $clog2(KICK_CYCLES + 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);
  localparam logic [KW-1:0] KICK_LAST = KW'(KICK_CYCLES - 1);
  localparam logic [KW-1:0] KICK_HIGH_AT =
    KW'(KICK_CYCLES - KICK_CYCLES / `SUP_KICK_HIGH_DIV);

  generate
    if (HOLD_CYCLES < 2) begin : g_bad_hold
      $error("hold count must be at least two");
    end
    if (KICK_CYCLES < `SUP_KICK_HIGH_DIV * 2) begin : g_bad_kick
      $error("kick window too short to split into eighths");
    end
    if (`SUP_KICK_PULSE_CYCLES < 1) begin : g_bad_pulse
      $error("shortest kick pulse is under one clock");
    end
  endgenerate

  // counter end test, shared by the hold and kick timers
  function automatic logic at_last(input logic [31:0] cnt,
                                   input logic [31:0] last);
    at_last = (cnt == last);
  endfunction : at_last

  debounce_if mr_bus ();

  supervisor_pkg::sup_state_t state_reg;
  supervisor_pkg::sup_state_t state_next;
  logic [HW-1:0] hold_cnt_reg;
  logic [HW-1:0] hold_cnt_next;
  logic [KW-1:0] kick_cnt_reg;
  logic [KW-1:0] kick_cnt_next;
  logic kick_prev_reg;
  logic kick_drive_reg;
  logic kick_oe_reg;
  logic rst_n_reg;
  logic rst_reg;
  logic [`SUP_CAUSE_W-1:0] cause_reg;
  logic [`SUP_CAUSE_W-1:0] cause_next;

  assign mr_bus.raw_n = manual_reset_n;

  mr_debounce #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
  ) u_mr_debounce (
    .mclk(mclk),
    .srst(srst),
    .port(mr_bus.filt)
  );

  // undervoltage flag is already synchronous, used as it comes
  wire uv_active = undervolt_in;
  wire mr_active = ~mr_bus.clean_n;
  wire src_active = uv_active | mr_active;

  wire in_run = (state_reg == supervisor_pkg::ST_RUN);
  wire in_hold = (state_reg == supervisor_pkg::ST_HOLD);

  // one-cycle sampling catches any pulse longer than a clock period
  wire kick_edge = watchdog_kick_in ^ kick_prev_reg;

  // a kick landing on the last count still saves the processor
  wire kick_expire = in_run & ~kick_edge &
                     at_last(32'(kick_cnt_reg), 32'(KICK_LAST));
  wire hold_done = in_hold &
                   at_last(32'(hold_cnt_reg), 32'(HOLD_LAST));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      supervisor_pkg::ST_ASSERT: begin
        if (!src_active) begin
          state_next = supervisor_pkg::ST_HOLD;
        end
      end
      supervisor_pkg::ST_HOLD: begin
        if (src_active) begin
          state_next = supervisor_pkg::ST_ASSERT;
        end else if (hold_done) begin
          state_next = supervisor_pkg::ST_RUN;
        end
      end
      supervisor_pkg::ST_RUN: begin
        if (src_active) begin
          state_next = supervisor_pkg::ST_ASSERT;
        end else if (kick_expire) begin
          state_next = supervisor_pkg::ST_HOLD;
        end
      end
      default: begin
        state_next = supervisor_pkg::ST_ASSERT;
      end
    endcase
  end

  wire stay_hold = in_hold & (state_next == supervisor_pkg::ST_HOLD);
  wire stay_run = in_run & (state_next == supervisor_pkg::ST_RUN);
  wire rst_next = (state_next != supervisor_pkg::ST_RUN);

  // any new source restarts the full hold period
  assign hold_cnt_next = stay_hold ? hold_cnt_reg + HW'(1) : '0;

  // zero through reset, counting from the first run cycle
  assign kick_cnt_next = (stay_run & ~kick_edge & ~mr_active) ?
                         kick_cnt_reg + KW'(1) : '0;

  // left floating, the pin follows this weak drive and kicks itself
  wire kick_drive_next = (kick_cnt_next >= KICK_HIGH_AT);

  wire [`SUP_CAUSE_W-1:0] cause_new = {kick_expire, mr_active, uv_active};
  // cause of the latest reset episode stays readable while running
  assign cause_next = (in_run & rst_next) ? cause_new :
                      (in_run ? cause_reg : cause_reg | cause_new);

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= supervisor_pkg::ST_ASSERT;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      hold_cnt_reg <= '0;
    end else begin
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      kick_cnt_reg <= '0;
    end else begin
      kick_cnt_reg <= kick_cnt_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      kick_prev_reg <= 1'b0;
    end else begin
      kick_prev_reg <= watchdog_kick_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      kick_drive_reg <= 1'b0;
    end else begin
      kick_drive_reg <= kick_drive_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      kick_oe_reg <= 1'b0;
    end else begin
      kick_oe_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rst_n_reg <= 1'b0;
    end else begin
      rst_n_reg <= ~rst_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rst_reg <= 1'b1;
    end else begin
      rst_reg <= rst_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cause_reg <= '0;
    end else begin
      cause_reg <= cause_next;
    end
  end

  assign sys_rst_n_out = rst_n_reg;
  assign sys_rst_out = rst_reg;
  assign kick_drive_out = kick_drive_reg;
  assign kick_drive_oe = kick_oe_reg;
  assign reset_cause_out = cause_reg;

endmodule : supervisor_reset_watchdog

`default_nettype wire

// >>> verification/kick_partner.sv
`timescale 1ns/100ps
`default_nettype none

module kick_partner (
  input wire logic mclk,
  input wire logic [1:0] mode,
  input wire logic drive,
  input wire logic oe,
  output logic pin
);
  logic ext = 1'b0;
  int cnt = 0;
  // 13-cycle high pulse every 30 cycles, well inside the window
  always @(negedge mclk) begin
    cnt = (cnt == 29) ? 0 : cnt + 1;
    ext = (mode == 2'h2) ? (cnt < 13) : 1'b0;
  end
  // mode 0 floats: weak drive wins, else the pin reads high
  assign pin = (mode != 2'h0) ? ext : (oe ? drive : ~ext);
endmodule : kick_partner

`default_nettype wire

// >>> verification/supervisor_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_defs.svh"

module supervisor_props #(
  parameter int HOLD_CYCLES = 40,
  parameter int KICK_CYCLES = 64,
  parameter int DEBOUNCE_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic undervolt_in,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  input wire logic kick_drive_out,
  input wire logic kick_drive_oe,
  input wire logic sys_rst_n_out,
  input wire logic sys_rst_out,
  input wire logic [`SUP_CAUSE_W-1:0] reset_cause_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // bounds sized for the short sim counts
  a_rst_complement: assert property (sys_rst_out == !sys_rst_n_out)
    else $error("reset outputs not complementary");
  a_uv_asserts: assert property (undervolt_in |=> !sys_rst_n_out)
    else $error("undervoltage did not assert reset");
  a_uv_hold: assert property ($fell(undervolt_in) |-> !sys_rst_n_out[*8])
    else $error("reset released too soon after undervoltage");
  a_manual_low: assert property (!manual_reset_n[*8] |=> !sys_rst_n_out)
    else $error("manual reset did not assert reset");
  a_kick_expiry: assert property ($rose(sys_rst_n_out) |->
    ##[1:70] (!sys_rst_n_out || $changed(watchdog_kick_in)))
    else $error("kick window overran without reset");
  a_drive_enabled: assert property (!srst |=> kick_drive_oe)
    else $error("weak kick drive not enabled");
  a_drive_low_early: assert property ($rose(sys_rst_n_out) |->
    !kick_drive_out[*8])
    else $error("weak kick drive high early in window");
  a_cause_set: assert property ($fell(sys_rst_n_out) |->
    reset_cause_out != 3'h0)
    else $error("reset asserted with no cause");
  c_uv: cover property (undervolt_in ##1 !sys_rst_n_out);
  c_manual: cover property (!manual_reset_n[*8]);
  c_drive: cover property ($rose(kick_drive_out));
endmodule : supervisor_props

bind supervisor_reset_watchdog supervisor_props #(
  .HOLD_CYCLES(HOLD_CYCLES), .KICK_CYCLES(KICK_CYCLES),
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) u_supervisor_props (
  .mclk(mclk), .srst(srst), .undervolt_in(undervolt_in),
  .manual_reset_n(manual_reset_n), .watchdog_kick_in(watchdog_kick_in),
  .kick_drive_out(kick_drive_out), .kick_drive_oe(kick_drive_oe),
  .sys_rst_n_out(sys_rst_n_out), .sys_rst_out(sys_rst_out),
  .reset_cause_out(reset_cause_out)
);

`default_nettype wire

// >>> verification/supervisor_reset_watchdog_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_defs.svh"

module supervisor_reset_watchdog_tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic uv = 1'b0;
  logic mr_n = 1'b1;
  logic [1:0] mode = 2'h0;
  logic pin, drv, oe, rst_n, rst;
  logic [`SUP_CAUSE_W-1:0] cause;
  int fail_count = 0;
  int compares = 0;
  always #2 mclk = ~mclk;
  supervisor_reset_watchdog #(.HOLD_CYCLES(40), .KICK_CYCLES(64),
    .DEBOUNCE_CYCLES(4)) u_supervisor_reset_watchdog (
    .mclk(mclk), .srst(srst), .undervolt_in(uv), .manual_reset_n(mr_n),
    .watchdog_kick_in(pin), .kick_drive_out(drv), .kick_drive_oe(oe),
    .sys_rst_n_out(rst_n), .sys_rst_out(rst), .reset_cause_out(cause));
  kick_partner u_kick_partner (.mclk(mclk), .mode(mode), .drive(drv),
    .oe(oe), .pin(pin));
  task automatic chk(input logic [2:0] e, input logic [2:0] a);
    compares++;
    if (a !== e) begin
      fail_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic wait_lvl(input logic v, input int lim);
    for (int i = 0; i < lim && rst_n !== v; i++) @(negedge mclk);
    chk({2'h0, v}, {2'h0, rst_n});
  endtask : wait_lvl
  task automatic t_power;
    cyc(30);
    chk(3'h0, {2'h0, rst_n});
    chk(3'h1, {2'h0, rst});
    wait_lvl(1'b1, 15);
    chk(3'h1, {2'h0, oe});
  endtask : t_power
  task automatic t_uv;
    uv = 1'b1;
    cyc(1);
    chk(3'h0, {2'h0, rst_n});
    chk(3'h1, {2'h0, rst});
    cyc(3);
    uv = 1'b0;
    cyc(35);
    chk(3'h0, {2'h0, rst_n});
    wait_lvl(1'b1, 10);
  endtask : t_uv
  task automatic t_mr;
    repeat (3) begin
      mr_n = 1'b0;
      cyc(2);
      mr_n = 1'b1;
      cyc(2);
    end
    chk(3'h1, {2'h0, rst_n});
    mr_n = 1'b0;
    cyc(20);
    chk(3'h0, {2'h0, rst_n});
    chk(3'h2, cause);
    mr_n = 1'b1;
    cyc(38);
    chk(3'h0, {2'h0, rst_n});
    wait_lvl(1'b1, 15);
  endtask : t_mr
  task automatic t_kick;
    logic seen;
    logic stuck;
    mode = 2'h2;
    cyc(300);
    chk(3'h1, {2'h0, rst_n});
    mode = 2'h1;
    wait_lvl(1'b0, 80);
    chk(3'h4, cause);
    wait_lvl(1'b1, 60);
    mode = 2'h0;
    seen = 1'b0;
    stuck = 1'b0;
    repeat (400) begin
      cyc(1);
      seen = seen | drv;
      stuck = stuck | ~rst_n;
    end
    chk(3'h1, {2'h0, rst_n});
    chk(3'h0, {2'h0, stuck});
    chk(3'h1, {2'h0, seen});
  endtask : t_kick
  task automatic print_verdict;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    cyc(2);
    srst = 1'b0;
    t_power();
    t_uv();
    t_mr();
    t_kick();
    print_verdict();
  end
  // whole run is near 1000 cycles
  initial begin
    #20000;
    fail_count++;
    print_verdict();
  end
endmodule : supervisor_reset_watchdog_tb

`default_nettype wire
